// >>> logic/bcu_branch_control_unit.sv
`timescale 1ns/100ps
// Summary of operation
// RL1 - Short jump is opcode plus signed offset byte, reach -128..+127 from next address
// RL2 - Long jump is three bytes and loads a full 16-bit target
// RL3 - Page jump opcode holds target bits 10..8, second byte holds bits 7..0
// RL4 - Page jump replaces low 11 PC bits, keeps upper 5, same 2K block
// RL5 - Indexed jump target is data pointer plus unsigned accumulator
// RL6 - Long call transfers control to a full 16-bit address
// RL7 - Page call substitutes 11 bits into next-instruction PC
// RL8 - Subroutine return resumes after the calling instruction
// RL9 - Interrupt return also tells interrupt controller it finished, if one active
// RL10 - Conditional jumps use signed offset relative to following instruction
// RL11 - Accumulator zero tests look at accumulator directly, no zero flag
// RL12 - Loop decrements operand, writes it back, jumps when result nonzero
// RL13 - Compare jumps only when its two operand bytes differ
// RL14 - Compare sets carry when first is below second, unsigned, else clears
// RL15 - Offset is two's complement byte added to PC when taken
// RL16 - Machine cycle is six states of two clocks, twelve clocks
// RL17 - Branches take two machine cycles, no-operation takes one
// RL18 - Calls push next address low byte first, returns pop it back
module bcu_branch_control_unit (
    input  wire logic               core_clk_i,
    input  wire logic               resetn_i,
    input  wire logic               instr_valid_i,
    input  wire bcu_pkg::bcu_instr_t instr_i,
    input  wire logic [15:0]        pc_next_i,
    input  wire logic [7:0]         acc_i,
    input  wire logic [15:0]        data_pointer_i,
    input  wire logic [7:0]         opnd_first_i,
    input  wire logic [7:0]         opnd_second_i,
    input  wire logic               irq_active_i,
    input  wire logic [7:0]         stack_rd_data_i,
    output logic                    ready_o,
    output logic                    mc_tick_o,
    output logic                    illegal_o,
    output logic                    done_o,
    output logic                    pc_load_o,
    output logic [15:0]             pc_target_o,
    output logic                    stack_push_o,
    output logic [7:0]              stack_wr_data_o,
    output logic                    stack_pop_o,
    output logic                    carry_we_o,
    output logic                    carry_o,
    output logic                    wb_we_o,
    output logic [7:0]              wb_data_o,
    output logic                    irq_done_o
);

    // ==========================================================
    // Functions
    // ==========================================================
    function automatic bcu_pkg::bcu_class_t decode_class(input logic [7:0] opc);
        if (opc == bcu_pkg::OPC_NO_OPERATION)              decode_class = bcu_pkg::CL_NO_OPERATION;
        else if (opc[4:0] == bcu_pkg::PAGE_JUMP_LOW)       decode_class = bcu_pkg::CL_PAGE_JUMP;
        else if (opc[4:0] == bcu_pkg::PAGE_CALL_LOW)       decode_class = bcu_pkg::CL_PAGE_CALL;
        else if (opc == bcu_pkg::OPC_SHORT_REL)            decode_class = bcu_pkg::CL_SHORT_JUMP;
        else if (opc == bcu_pkg::OPC_LONG_JUMP)            decode_class = bcu_pkg::CL_LONG_JUMP;
        else if (opc == bcu_pkg::OPC_INDEXED)              decode_class = bcu_pkg::CL_INDEXED_JUMP;
        else if (opc == bcu_pkg::OPC_LONG_CALL)            decode_class = bcu_pkg::CL_LONG_CALL;
        else if (opc == bcu_pkg::OPC_SUB_RETURN)           decode_class = bcu_pkg::CL_SUB_RETURN;
        else if (opc == bcu_pkg::OPC_INT_RETURN)           decode_class = bcu_pkg::CL_INT_RETURN;
        else if (opc == bcu_pkg::OPC_ACC_ZERO)             decode_class = bcu_pkg::CL_ACC_ZERO;
        else if (opc == bcu_pkg::OPC_ACC_NONZERO)          decode_class = bcu_pkg::CL_ACC_NONZERO;
        else if (opc == bcu_pkg::OPC_LOOP_DIR)             decode_class = bcu_pkg::CL_LOOP;
        else if (opc[7:3] == bcu_pkg::LOOP_REG_HIGH)       decode_class = bcu_pkg::CL_LOOP;
        else if (opc == bcu_pkg::OPC_CMP_ACC_IMM)          decode_class = bcu_pkg::CL_COMPARE;
        else if (opc == bcu_pkg::OPC_CMP_ACC_DIR)          decode_class = bcu_pkg::CL_COMPARE;
        else if (opc[7:1] == bcu_pkg::CMP_IND_HIGH)        decode_class = bcu_pkg::CL_COMPARE;
        else if (opc[7:3] == bcu_pkg::CMP_REG_HIGH)        decode_class = bcu_pkg::CL_COMPARE;
        else                                               decode_class = bcu_pkg::CL_NONE;
    endfunction

    // Two-byte relative forms carry the offset in byte1, three-byte forms in byte2
    function automatic logic [7:0] rel_offset(input bcu_pkg::bcu_instr_t ins);
        if ((ins.opcode == bcu_pkg::OPC_LOOP_DIR) || (ins.opcode == bcu_pkg::OPC_CMP_ACC_IMM) ||
            (ins.opcode == bcu_pkg::OPC_CMP_ACC_DIR) || (ins.opcode[7:1] == bcu_pkg::CMP_IND_HIGH) ||
            (ins.opcode[7:3] == bcu_pkg::CMP_REG_HIGH)) begin
            rel_offset = ins.byte2;
        end else begin
            rel_offset = ins.byte1;
        end
    endfunction

    function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] off);
        rel_target = pc + {{8{off[7]}}, off};
    endfunction

    function automatic logic [15:0] page_target(input logic [15:0] pc, input logic [7:0] opc,
                                                input logic [7:0] low);
        page_target = {pc[15:11], opc[7:5], low};
    endfunction

    // ==========================================================
    // Reset release
    // ==========================================================
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ==========================================================
    // Machine cycle sequencer
    // ==========================================================
    typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_SECOND} bcu_state_t;

    logic [3:0]          phase_ff;
    bcu_state_t          state_ff;
    bcu_pkg::bcu_class_t cls_ff;
    bcu_pkg::bcu_class_t dec_cls;
    logic                take;
    logic                finish;
    logic                is_call;
    logic                is_return;

    assign dec_cls   = decode_class(instr_i.opcode);
    assign take      = ready_o && mc_tick_o && instr_valid_i && (dec_cls != bcu_pkg::CL_NONE);
    assign finish    = (phase_ff == bcu_pkg::PH_LAST) &&
                       ((state_ff == ST_SECOND) ||
                        ((state_ff == ST_FIRST) && (cls_ff == bcu_pkg::CL_NO_OPERATION)));
    assign is_call   = (cls_ff == bcu_pkg::CL_LONG_CALL) || (cls_ff == bcu_pkg::CL_PAGE_CALL);
    assign is_return = (cls_ff == bcu_pkg::CL_SUB_RETURN) || (cls_ff == bcu_pkg::CL_INT_RETURN);

    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            phase_ff  <= bcu_pkg::PH_FIRST;
            mc_tick_o <= 1'b0;
        end else begin
            phase_ff  <= (phase_ff == bcu_pkg::PH_LAST) ? bcu_pkg::PH_FIRST : phase_ff + 4'h1; // RL16
            mc_tick_o <= (phase_ff == bcu_pkg::PH_LAST); // RL16
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff  <= ST_IDLE;
            ready_o   <= 1'b1;
            illegal_o <= 1'b0;
        end else begin
            illegal_o <= ready_o && mc_tick_o && instr_valid_i && (dec_cls == bcu_pkg::CL_NONE);
            unique case (state_ff)
                ST_IDLE: begin
                    if (take) begin
                        state_ff <= ST_FIRST;
                        ready_o  <= 1'b0;
                    end
                end
                ST_FIRST: begin
                    if (finish) begin
                        state_ff <= ST_IDLE; // RL17
                        ready_o  <= 1'b1;
                    end else if (phase_ff == bcu_pkg::PH_LAST) begin
                        state_ff <= ST_SECOND; // RL17
                    end
                end
                ST_SECOND: begin
                    if (finish) begin
                        state_ff <= ST_IDLE;
                        ready_o  <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Operand capture
    // ==========================================================
    bcu_pkg::bcu_instr_t ins_ff;
    logic [15:0]         pc_ff;
    logic [15:0]         dp_ff;
    logic [7:0]          acc_ff;
    logic [7:0]          opa_ff;
    logic [7:0]          opb_ff;
    logic [7:0]          off_ff;
    logic                irq_ff;

    // Operands are frozen at acceptance, so the core may move on with its buses
    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cls_ff <= bcu_pkg::CL_NONE;
            ins_ff <= '0;
            pc_ff  <= bcu_pkg::ADDR_RESET;
            dp_ff  <= bcu_pkg::ADDR_RESET;
            acc_ff <= bcu_pkg::BYTE_RESET;
            opa_ff <= bcu_pkg::BYTE_RESET;
            opb_ff <= bcu_pkg::BYTE_RESET;
            off_ff <= bcu_pkg::BYTE_RESET;
            irq_ff <= 1'b0;
        end else if (take) begin
            cls_ff <= dec_cls;
            ins_ff <= instr_i;
            pc_ff  <= pc_next_i;
            dp_ff  <= data_pointer_i;
            acc_ff <= acc_i;
            opa_ff <= opnd_first_i;
            opb_ff <= opnd_second_i;
            off_ff <= rel_offset(instr_i); // RL10
            irq_ff <= irq_active_i;
        end
    end

    // ==========================================================
    // Stack traffic
    // ==========================================================
    logic [7:0] ret_hi_ff;
    logic [7:0] ret_lo_ff;
    logic [1:0] pop_wait_ff;

    // Pop data returns one cycle after the pop strobe; high byte comes off first
    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            stack_push_o    <= 1'b0;
            stack_wr_data_o <= bcu_pkg::BYTE_RESET;
            stack_pop_o     <= 1'b0;
            pop_wait_ff     <= 2'b00;
            ret_hi_ff       <= bcu_pkg::BYTE_RESET;
            ret_lo_ff       <= bcu_pkg::BYTE_RESET;
        end else begin
            stack_push_o <= 1'b0;
            stack_pop_o  <= 1'b0;
            pop_wait_ff  <= {stack_pop_o && (phase_ff == bcu_pkg::PH_XFER_A + 4'h1),
                             stack_pop_o && (phase_ff == bcu_pkg::PH_XFER_B + 4'h1)};
            if (state_ff == ST_FIRST && is_call && phase_ff == bcu_pkg::PH_XFER_A) begin
                stack_push_o    <= 1'b1; // RL18
                stack_wr_data_o <= pc_ff[7:0];
            end
            if (state_ff == ST_FIRST && is_call && phase_ff == bcu_pkg::PH_XFER_B) begin
                stack_push_o    <= 1'b1; // RL18
                stack_wr_data_o <= pc_ff[15:8];
            end
            if (state_ff == ST_FIRST && is_return &&
                (phase_ff == bcu_pkg::PH_XFER_A || phase_ff == bcu_pkg::PH_XFER_B)) begin
                stack_pop_o <= 1'b1; // RL18
            end
            if (pop_wait_ff[1]) ret_hi_ff <= stack_rd_data_i; // RL18
            if (pop_wait_ff[0]) ret_lo_ff <= stack_rd_data_i; // RL18
        end
    end

    // ==========================================================
    // Target and condition evaluation
    // ==========================================================
    logic [15:0] nxt_target;
    logic        nxt_taken;
    logic [7:0]  loop_dec;

    assign loop_dec = opa_ff - 8'h01;

    always_comb begin
        nxt_target = rel_target(pc_ff, off_ff); // RL1 RL10 RL15
        nxt_taken  = 1'b1;
        unique case (cls_ff)
            bcu_pkg::CL_LONG_JUMP, bcu_pkg::CL_LONG_CALL:
                nxt_target = {ins_ff.byte1, ins_ff.byte2}; // RL2 RL6
            bcu_pkg::CL_PAGE_JUMP, bcu_pkg::CL_PAGE_CALL:
                nxt_target = page_target(pc_ff, ins_ff.opcode, ins_ff.byte1); // RL3 RL4 RL7
            bcu_pkg::CL_INDEXED_JUMP:
                nxt_target = dp_ff + {8'h00, acc_ff}; // RL5
            bcu_pkg::CL_SUB_RETURN, bcu_pkg::CL_INT_RETURN:
                nxt_target = {ret_hi_ff, ret_lo_ff}; // RL8
            bcu_pkg::CL_ACC_ZERO:
                nxt_taken = (acc_ff == 8'h00); // RL11
            bcu_pkg::CL_ACC_NONZERO:
                nxt_taken = (acc_ff != 8'h00); // RL11
            bcu_pkg::CL_LOOP:
                nxt_taken = (loop_dec != 8'h00); // RL12
            bcu_pkg::CL_COMPARE:
                nxt_taken = (opa_ff != opb_ff); // RL13
            bcu_pkg::CL_NO_OPERATION, bcu_pkg::CL_NONE:
                nxt_taken = 1'b0;
            default: nxt_taken = 1'b1;
        endcase
    end

    // ==========================================================
    // Completion outputs
    // ==========================================================
    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            done_o      <= 1'b0;
            pc_load_o   <= 1'b0;
            pc_target_o <= bcu_pkg::ADDR_RESET;
            carry_we_o  <= 1'b0;
            carry_o     <= 1'b0;
            wb_we_o     <= 1'b0;
            wb_data_o   <= bcu_pkg::BYTE_RESET;
            irq_done_o  <= 1'b0;
        end else begin
            done_o     <= finish; // RL17
            pc_load_o  <= finish && nxt_taken;
            carry_we_o <= finish && (cls_ff == bcu_pkg::CL_COMPARE);
            wb_we_o    <= finish && (cls_ff == bcu_pkg::CL_LOOP); // RL12
            irq_done_o <= finish && (cls_ff == bcu_pkg::CL_INT_RETURN) && irq_ff; // RL9
            if (finish) begin
                pc_target_o <= nxt_taken ? nxt_target : pc_ff;
                carry_o     <= (opa_ff < opb_ff); // RL14
                wb_data_o   <= loop_dec; // RL12
            end
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_ff);

    a_mc_period: assert property (mc_tick_o |=> !mc_tick_o [*8] ##1 !mc_tick_o [*3] ##1 mc_tick_o) // RL16
        else $error("machine cycle tick not every twelve clocks");
    a_nop_length: assert property (take && dec_cls == bcu_pkg::CL_NO_OPERATION |-> ##12 done_o && !pc_load_o) // RL17
        else $error("no-operation did not finish in one machine cycle");
    a_branch_length: assert property (take && dec_cls != bcu_pkg::CL_NO_OPERATION |-> ##1 !done_o [*8] // RL17
                                      ##1 !done_o [*8] ##1 !done_o [*7] ##1 done_o)
        else $error("branch did not finish in two machine cycles");
    a_short_target: assert property (done_o && cls_ff == bcu_pkg::CL_SHORT_JUMP |-> pc_load_o && // RL15
                                     pc_target_o == pc_ff + {{8{off_ff[7]}}, off_ff})
        else $error("short jump target wrong");
    a_long_target: assert property (done_o && // RL2
                                    (cls_ff == bcu_pkg::CL_LONG_JUMP || cls_ff == bcu_pkg::CL_LONG_CALL)
                                    |-> pc_load_o && pc_target_o == {ins_ff.byte1, ins_ff.byte2})
        else $error("long target wrong");
    a_page_block: assert property (done_o && // RL4
                                   (cls_ff == bcu_pkg::CL_PAGE_JUMP || cls_ff == bcu_pkg::CL_PAGE_CALL)
                                   |-> pc_target_o[15:11] == pc_ff[15:11] &&
                                       pc_target_o[10:0] == {ins_ff.opcode[7:5], ins_ff.byte1})
        else $error("page target left its 2K block");
    a_indexed_sum: assert property (done_o && cls_ff == bcu_pkg::CL_INDEXED_JUMP // RL5
                                    |-> pc_target_o == dp_ff + {8'h00, acc_ff})
        else $error("indexed target wrong");
    a_call_push: assert property (take && // RL18
                                  (dec_cls == bcu_pkg::CL_LONG_CALL || dec_cls == bcu_pkg::CL_PAGE_CALL)
                                  |-> ##3 stack_push_o && stack_wr_data_o == $past(pc_next_i[7:0], 3)
                                      ##4 stack_push_o && stack_wr_data_o == $past(pc_next_i[15:8], 7))
        else $error("call push order or data wrong");
    a_return_pop: assert property (take && dec_cls == bcu_pkg::CL_SUB_RETURN |-> ##3 stack_pop_o // RL8
                                   ##4 stack_pop_o ##17 done_o && pc_load_o &&
                                   pc_target_o == {$past(stack_rd_data_i, 20), $past(stack_rd_data_i, 16)})
        else $error("return did not use popped address");
    a_irq_notify: assert property (done_o |-> irq_done_o == (cls_ff == bcu_pkg::CL_INT_RETURN && irq_ff)) // RL9
        else $error("interrupt finish notice wrong");
    a_acc_test: assert property (done_o && cls_ff == bcu_pkg::CL_ACC_ZERO |-> pc_load_o == (acc_ff == 8'h00)) // RL11
        else $error("accumulator zero test wrong");
    a_loop_count: assert property (done_o && cls_ff == bcu_pkg::CL_LOOP |-> wb_we_o && // RL12
                                   wb_data_o == opa_ff - 8'h01 && pc_load_o == (opa_ff != 8'h01))
        else $error("loop decrement or branch wrong");
    a_compare_carry: assert property (done_o && cls_ff == bcu_pkg::CL_COMPARE |-> carry_we_o && // RL13
                                      carry_o == (opa_ff < opb_ff) && pc_load_o == (opa_ff != opb_ff))
        else $error("compare carry or branch wrong");

    c_nop_run:      cover property (take && dec_cls == bcu_pkg::CL_NO_OPERATION);
    c_call_taken:   cover property (done_o && pc_load_o && cls_ff == bcu_pkg::CL_LONG_CALL);
    c_loop_exit:    cover property (done_o && cls_ff == bcu_pkg::CL_LOOP && !pc_load_o);
    c_irq_finished: cover property (irq_done_o);

endmodule

// >>> logic/bcu_pkg.sv
package bcu_pkg;

    // ==========================================================
    // Machine cycle timing
    // ==========================================================
    localparam int          OSC_PER_STATE = 2;
    localparam int          STATES_PER_MC = 6;
    localparam logic [3:0]  PH_FIRST      = 4'h0;
    localparam logic [3:0]  PH_LAST       = 4'(OSC_PER_STATE * STATES_PER_MC - 1);
    // Stack transfers happen in state 2 and state 4 of the first machine cycle
    localparam logic [3:0]  PH_XFER_A     = 4'(OSC_PER_STATE * 1);
    localparam logic [3:0]  PH_XFER_B     = 4'(OSC_PER_STATE * 3);

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [15:0] ADDR_RESET    = 16'h0000;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;

    // ==========================================================
    // Opcodes
    // ==========================================================
    localparam logic [7:0]  OPC_NO_OPERATION   = 8'h00;
    localparam logic [7:0]  OPC_LONG_JUMP      = 8'h02;
    localparam logic [7:0]  OPC_LONG_CALL      = 8'h12;
    localparam logic [7:0]  OPC_SUB_RETURN     = 8'h22;
    localparam logic [7:0]  OPC_INT_RETURN     = 8'h32;
    localparam logic [7:0]  OPC_ACC_ZERO       = 8'h60;
    localparam logic [7:0]  OPC_ACC_NONZERO    = 8'h70;
    localparam logic [7:0]  OPC_INDEXED        = 8'h73;
    localparam logic [7:0]  OPC_SHORT_REL      = 8'h80;
    localparam logic [7:0]  OPC_CMP_ACC_IMM    = 8'hB4;
    localparam logic [7:0]  OPC_CMP_ACC_DIR    = 8'hB5;
    localparam logic [7:0]  OPC_LOOP_DIR       = 8'hD5;
    localparam logic [4:0]  PAGE_JUMP_LOW      = 5'h01;
    localparam logic [4:0]  PAGE_CALL_LOW      = 5'h11;
    localparam logic [6:0]  CMP_IND_HIGH       = 7'h5B;
    localparam logic [4:0]  CMP_REG_HIGH       = 5'h17;
    localparam logic [4:0]  LOOP_REG_HIGH      = 5'h1B;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [3:0] {
        CL_NONE, CL_NO_OPERATION, CL_SHORT_JUMP, CL_LONG_JUMP, CL_PAGE_JUMP,
        CL_INDEXED_JUMP, CL_LONG_CALL, CL_PAGE_CALL, CL_SUB_RETURN,
        CL_INT_RETURN, CL_ACC_ZERO, CL_ACC_NONZERO, CL_LOOP, CL_COMPARE
    } bcu_class_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
    } bcu_instr_t;

endpackage

// >>> verif/bcu_branch_control_unit_bench.sv
`timescale 1ns/100ps
module bcu_branch_control_unit_bench;
    // ==========================================================
    // Stimulus and observation
    // ==========================================================
    logic                core_clk_i = 1'b0;
    logic                resetn_i = 1'b0;
    logic                valid = 1'b0;
    bcu_pkg::bcu_instr_t instr = '0;
    logic [15:0]         pc_next = 16'h0000, data_pointer = 16'h0000;
    logic [7:0]          acc = 8'h00, opa = 8'h00, opb = 8'h00, rd_data = 8'h00;
    logic                irq = 1'b0;
    logic                ready, tick, illegal, done, ld, push, pop, c_we, c, wb_we, irq_done;
    logic [15:0]         tgt;
    logic [7:0]          wr_data, wb_data, pop_bytes[2];
    logic [7:0]          pushes[$];
    int                  err_total = 0, comparisons = 0, cycles = 0, pop_idx = 0, hold = 0;
    logic                s_cwe, s_c, s_wwe, s_irq;
    logic [7:0]          s_wb;

    bcu_branch_control_unit i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .instr_valid_i(valid),
        .instr_i(instr), .pc_next_i(pc_next), .acc_i(acc), .data_pointer_i(data_pointer), .opnd_first_i(opa),
        .opnd_second_i(opb), .irq_active_i(irq), .stack_rd_data_i(rd_data), .ready_o(ready), .mc_tick_o(tick),
        .illegal_o(illegal), .done_o(done), .pc_load_o(ld), .pc_target_o(tgt), .stack_push_o(push),
        .stack_wr_data_o(wr_data), .stack_pop_o(pop), .carry_we_o(c_we), .carry_o(c), .wb_we_o(wb_we),
        .wb_data_o(wb_data), .irq_done_o(irq_done));

    initial begin
        forever #20 core_clk_i = ~core_clk_i;
    end

    // Stack byte stays valid two cycles past the pop, then is scrambled
    always @(negedge core_clk_i) begin
        if (pop === 1'b1) begin
            rd_data <= pop_bytes[pop_idx % 2];
            pop_idx <= pop_idx + 1;
            hold <= 2;
        end else if (hold > 0) begin
            hold <= hold - 1;
            if (hold == 1) rd_data <= ~rd_data;
        end
    end
    always @(negedge core_clk_i) begin
        if (push === 1'b1) pushes.push_back(wr_data);
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            give_verdict();
        end
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Waits for tick and ready, then offers at that tick edge, so back-to-back takes are exercised
    task automatic run(input logic [7:0] op, b1, b2, input logic [15:0] pc, dp, input logic [7:0] a, f, s,
                       input logic ir, input int lat, input logic exp_ld, input logic [15:0] exp_tgt);
        int n;
        n = 1;
        while (!(tick === 1'b1 && ready === 1'b1)) @(negedge core_clk_i);
        instr = '{op, b1, b2};
        pc_next = pc; data_pointer = dp; acc = a; opa = f; opb = s; irq = ir; valid = 1'b1;
        @(negedge core_clk_i);
        valid = 1'b0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge core_clk_i);
            n++;
        end
        s_cwe = c_we; s_c = c; s_wwe = wb_we; s_wb = wb_data; s_irq = irq_done;
        chk("latency", 16'(lat), 16'(n));
        chk("pc_load", {15'h0, exp_ld}, {15'h0, ld});
        chk("pc_target", exp_tgt, tgt);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_jumps();
        run(8'h80, 8'h80, 8'h00, 16'h1000, 16'h0, 8'h0, 8'h0, 8'h0, 1'b0, 24, 1'b1, 16'h0F80);
        run(8'h80, 8'h7F, 8'h00, 16'h1000, 16'h0, 8'h0, 8'h0, 8'h0, 1'b0, 24, 1'b1, 16'h107F);
        run(8'h02, 8'hAB, 8'hCD, 16'h1000, 16'h0, 8'h0, 8'h0, 8'h0, 1'b0, 24, 1'b1, 16'hABCD);
        run(8'hA1, 8'h34, 8'h00, 16'hF7FE, 16'h0, 8'h0, 8'h0, 8'h0, 1'b0, 24, 1'b1, 16'hF534);
        run(8'h73, 8'h00, 8'h00, 16'h0000, 16'hFFF0, 8'hFF, 8'h0, 8'h0, 1'b0, 24, 1'b1, 16'h00EF);
        $display("test jumps done");
    endtask
    task automatic t_calls();
        pushes = {};
        run(8'h12, 8'h23, 8'h45, 16'h1234, 16'h0, 8'h0, 8'h0, 8'h0, 1'b0, 24, 1'b1, 16'h2345);
        run(8'h71, 8'h56, 8'h00, 16'h4802, 16'h0, 8'h0, 8'h0, 8'h0, 1'b0, 24, 1'b1, 16'h4B56);
        chk("pushes", 16'h0004, 16'(pushes.size()));
        chk("push01", 16'h1234, {pushes[1], pushes[0]});
        chk("push23", 16'h4802, {pushes[3], pushes[2]});
        pop_bytes[0] = 8'h12; pop_bytes[1] = 8'h34; pop_idx = 0;
        run(8'h22, 8'h00, 8'h00, 16'h0100, 16'h0, 8'h0, 8'h0, 8'h0, 1'b1, 24, 1'b1, 16'h1234);
        chk("irq_done_ret", 16'h0, {15'h0, s_irq});
        pop_bytes[0] = 8'hBE; pop_bytes[1] = 8'hEF; pop_idx = 0;
        run(8'h32, 8'h00, 8'h00, 16'h0100, 16'h0, 8'h0, 8'h0, 8'h0, 1'b1, 24, 1'b1, 16'hBEEF);
        chk("irq_done_on", 16'h1, {15'h0, s_irq});
        pop_idx = 0;
        run(8'h32, 8'h00, 8'h00, 16'h0100, 16'h0, 8'h0, 8'h0, 8'h0, 1'b0, 24, 1'b1, 16'hBEEF);
        chk("irq_done_off", 16'h0, {15'h0, s_irq});
        $display("test calls done");
    endtask
    task automatic t_cond();
        run(8'h60, 8'h7F, 8'h00, 16'h0100, 16'h0, 8'h00, 8'h0, 8'h0, 1'b0, 24, 1'b1, 16'h017F);
        run(8'h60, 8'h7F, 8'h00, 16'h0100, 16'h0, 8'h01, 8'h0, 8'h0, 1'b0, 24, 1'b0, 16'h0100);
        run(8'h70, 8'hFE, 8'h00, 16'h0100, 16'h0, 8'h80, 8'h0, 8'h0, 1'b0, 24, 1'b1, 16'h00FE);
        run(8'hD5, 8'h00, 8'h10, 16'h0200, 16'h0, 8'h0, 8'h01, 8'h0, 1'b0, 24, 1'b0, 16'h0200);
        chk("wb_zero", 16'h0100, {7'h0, s_wwe, s_wb});
        run(8'hD8, 8'hF0, 8'h00, 16'h0200, 16'h0, 8'h0, 8'h00, 8'h0, 1'b0, 24, 1'b1, 16'h01F0);
        chk("wb_wrap", 16'h01FF, {7'h0, s_wwe, s_wb});
        run(8'hB4, 8'h00, 8'h05, 16'h0300, 16'h0, 8'h0, 8'h05, 8'h09, 1'b0, 24, 1'b1, 16'h0305);
        chk("carry_lt", 16'h0101, {7'h0, s_cwe, 7'h0, s_c});
        run(8'hB5, 8'h00, 8'h05, 16'h0300, 16'h0, 8'h0, 8'h80, 8'h80, 1'b0, 24, 1'b0, 16'h0300);
        chk("carry_eq", 16'h0100, {7'h0, s_cwe, 7'h0, s_c});
        run(8'hB6, 8'h00, 8'hFB, 16'h0300, 16'h0, 8'h0, 8'hF0, 8'h05, 1'b0, 24, 1'b1, 16'h02FB);
        chk("carry_gt", 16'h0100, {7'h0, s_cwe, 7'h0, s_c});
        run(8'hBF, 8'h00, 8'h01, 16'h0300, 16'h0, 8'h0, 8'h01, 8'hFF, 1'b0, 24, 1'b1, 16'h0301);
        chk("carry_reg", 16'h0101, {7'h0, s_cwe, 7'h0, s_c});
        $display("test conditional done");
    endtask
    task automatic t_timing();
        int n;
        n = 0;
        run(8'h00, 8'h00, 8'h00, 16'h0400, 16'h0, 8'h0, 8'h0, 8'h0, 1'b0, 12, 1'b0, 16'h0400);
        @(negedge core_clk_i);
        while (tick !== 1'b1 && n < 20) begin
            @(negedge core_clk_i);
            n++;
        end
        chk("tick_period", 16'd11, 16'(n));
        instr = '{8'h04, 8'h00, 8'h00};
        valid = 1'b1;
        @(negedge core_clk_i);
        valid = 1'b0;
        chk("illegal", 16'h1, {15'h0, illegal});
        $display("test timing done");
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (2) @(negedge core_clk_i);
        resetn_i = 1'b1;
        t_jumps();
        t_calls();
        t_cond();
        t_timing();
        give_verdict();
    end
endmodule
